// *** design/boot_image_loader.sv ***
// parallel configuration port receiver and boot header interpreter
`timescale 1ns/1ps
module boot_image_loader import boot_loader_pkg::*; #(
  parameter logic [31:0] IMAGE_ID_VALUE = 32'h1234ABCD  // arbitrary value
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // configuration port pins
  input wire logic config_port_clock_i,
  input wire logic port_select_n_i,
  input wire logic read_write_n_i,
  input wire logic [31:0] port_data_lines_i,
  output logic [31:0] port_data_lines_o,
  output logic [31:0] port_data_lines_oe_o,
  output logic flow_hold_o,
  // status readback word driven in read direction
  input wire logic [31:0] readback_data_i,
  // decoded header
  output logic [1:0] bus_width_o,
  output logic [2:0] key_source_o,
  output logic encrypted_o,
  output logic [31:0] loader_start_o,
  output logic [31:0] loader_len_o,
  output logic [31:0] loader_total_len_o,
  output logic [31:0] cfg_load_addr_o,
  output logic [31:0] cfg_len_o,
  output logic [31:0] cfg_total_len_o,
  output logic [31:0] shutter_o,
  output logic [31:0] meta_offset_o,
  output logic [95:0] header_iv_o,
  output logic [95:0] cfg_iv_o,
  // register initialisation write strobe
  output logic reg_wr_o,
  output logic [31:0] reg_addr_o,
  output logic [31:0] reg_data_o,
  // status
  output logic header_done_o,
  output logic boot_error_o
);

  // ==========================================================
  // pin synchronisers
  logic [1:0] clk_s_q, cs_s_q, rw_s_q;
  logic [31:0] dat_a_q, dat_b_q;
  logic clk_prev_q, port_rise, port_on, wr_mode;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      clk_s_q <= 2'h0;
      cs_s_q <= 2'h3;
      rw_s_q <= 2'h3;
      dat_a_q <= 32'h0;
      dat_b_q <= 32'h0;
      clk_prev_q <= 1'h0;
    end else begin
      clk_s_q <= {clk_s_q[0], config_port_clock_i};
      cs_s_q <= {cs_s_q[0], port_select_n_i};
      rw_s_q <= {rw_s_q[0], read_write_n_i};
      dat_a_q <= port_data_lines_i;
      dat_b_q <= dat_a_q;
      clk_prev_q <= clk_s_q[1];
    end
  end

  // data passes the same two flop stages as the clock, so it is taken in the same cycle the edge is seen
  assign port_rise = clk_s_q[1] && !clk_prev_q;
  assign port_on = !cs_s_q[1];
  assign wr_mode = port_on && !rw_s_q[1];

  // read direction drives the readback word; write direction releases the lines
  logic [31:0] rd_q, rd_d, oe_q, oe_d;
  always_comb begin
    rd_d = readback_data_i;
    oe_d = (port_on && rw_s_q[1]) ? 32'hFFFFFFFF : 32'h0;
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_q <= 32'h0;
      oe_q <= 32'h0;
    end else begin
      rd_q <= rd_d;
      oe_q <= oe_d;
    end
  end
  assign port_data_lines_o = rd_q;
  assign port_data_lines_oe_o = oe_q;

  // ==========================================================
  // byte assembly into 32-bit words
  bus_width_t width_q, width_d;
  logic width_known_q, width_known_d, push, fifo_ready;
  logic [31:0] asm_q, asm_d, push_data;
  logic [1:0] lane_q, lane_d;

  // index of the last port beat in a word (port beats per word minus one)
  function automatic logic [1:0] beats_per_word(input bus_width_t w);
    unique case (w)
      WIDTH_X8: beats_per_word = 2'h3;
      WIDTH_X16: beats_per_word = 2'h1;
      WIDTH_X32: beats_per_word = 2'h0;
    endcase
  endfunction

  always_comb begin
    width_d = width_q;
    width_known_d = width_known_q;
    asm_d = asm_q;
    lane_d = lane_q;
    push = 1'b0;
    push_data = asm_q;
    if (!port_on) begin
      lane_d = 2'h0;
    end else if (wr_mode && port_rise) begin
      if (!width_known_q) begin
        // detect width from the sync byte on the low lane, then collect from the next beat
        if (dat_b_q[7:0] == WIDTH_SYNC_X32) begin
          width_d = WIDTH_X32;
          width_known_d = 1'b1;
        end else if (dat_b_q[7:0] == WIDTH_SYNC_X16) begin
          width_d = WIDTH_X16;
          width_known_d = 1'b1;
        end else if (dat_b_q[7:0] == WIDTH_SYNC_X8) begin
          width_d = WIDTH_X8;
          width_known_d = 1'b1;
        end
      end else begin
        unique case (width_q)
          WIDTH_X8: asm_d[lane_q*8 +: 8] = dat_b_q[7:0];
          WIDTH_X16: asm_d[lane_q[0]*16 +: 16] = dat_b_q[15:0];
          WIDTH_X32: asm_d = dat_b_q;
        endcase
        push_data = asm_d;
        if (lane_q == beats_per_word(width_q)) begin
          push = 1'b1;
          lane_d = 2'h0;
        end else begin
          lane_d = lane_q + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      width_q <= WIDTH_X8;
      width_known_q <= 1'b0;
      asm_q <= 32'h0;
      lane_q <= 2'h0;
    end else begin
      width_q <= width_d;
      width_known_q <= width_known_d;
      asm_q <= asm_d;
      lane_q <= lane_d;
    end
  end

  // ==========================================================
  // buffer and flow hold
  logic pop_valid, pop_ready;
  logic [31:0] pop_data;
  logic [$clog2(FIFO_DEPTH):0] level;

  loader_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .in_valid_i(push), .in_ready_o(fifo_ready), .in_data_i(push_data),
    .out_valid_o(pop_valid), .out_ready_i(pop_ready), .out_data_o(pop_data),
    .level_o(level)
  );

  // room left in port beats; hold once 24 beats or fewer remain. a 16-word
  // buffer holds only 16 x32 beats, so in x32 the hold is on from the start.
  logic [7:0] room_beats;
  always_comb begin
    room_beats = 8'(FIFO_DEPTH) - 8'(level);
    unique case (width_q)
      WIDTH_X8: room_beats = {room_beats[5:0], 2'h0};
      WIDTH_X16: room_beats = {room_beats[6:0], 1'h0};
      WIDTH_X32: room_beats = room_beats;
    endcase
  end
  assign flow_hold_o = port_on && (room_beats <= 8'(HOLD_MARGIN) || !fifo_ready);

  // ==========================================================
  // header parse
  typedef enum logic [1:0] {
    PARSE_RUN,
    PARSE_DONE,
    PARSE_FAIL
  } parse_t;
  parse_t st_q, st_d;
  logic [11:0] ofs_q, ofs_d;
  logic [31:0] key_q, key_d, pair_addr_q, pair_addr_d;
  logic [31:0] f_lst_q, f_lst_d, f_ll_q, f_ll_d, f_llt_q, f_llt_d;
  logic [31:0] f_cla_q, f_cla_d, f_cl_q, f_cl_d, f_clt_q, f_clt_d;
  logic [31:0] f_sh_q, f_sh_d, f_mo_q, f_mo_d;
  logic [95:0] hiv_q, hiv_d, civ_q, civ_d;
  logic wr_q, wr_d;
  logic [31:0] wa_q, wa_d, wv_q, wv_d;

  assign pop_ready = (st_q != PARSE_FAIL);

  always_comb begin
    st_d = st_q;
    ofs_d = ofs_q;
    key_d = key_q;
    pair_addr_d = pair_addr_q;
    {f_lst_d, f_ll_d, f_llt_d, f_cla_d} = {f_lst_q, f_ll_q, f_llt_q, f_cla_q};
    {f_cl_d, f_clt_d, f_sh_d, f_mo_d} = {f_cl_q, f_clt_q, f_sh_q, f_mo_q};
    hiv_d = hiv_q;
    civ_d = civ_q;
    wr_d = 1'b0;
    wa_d = wa_q;
    wv_d = wv_q;
    if (st_q == PARSE_RUN && pop_valid) begin
      ofs_d = ofs_q + 12'h4;
      unique case (ofs_q)
        OFS_FLASH_MODE: if (pop_data != FLASH_MODE_WORD) st_d = PARSE_FAIL;
        OFS_IMAGE_ID: if (pop_data != IMAGE_ID_VALUE) st_d = PARSE_FAIL;
        OFS_KEY_SOURCE: key_d = pop_data;
        OFS_LOADER_START: f_lst_d = pop_data;
        OFS_LOADER_LEN: f_ll_d = pop_data;
        OFS_LOADER_TOTAL_LEN: f_llt_d = pop_data;
        OFS_CFG_LOAD_ADDR: f_cla_d = pop_data;
        OFS_CFG_LEN: f_cl_d = pop_data;
        OFS_CFG_TOTAL_LEN: f_clt_d = pop_data;
        OFS_SHUTTER: f_sh_d = pop_data;
        OFS_META_OFFSET: f_mo_d = pop_data;
        default: ;
      endcase
      // initialisation vectors, first word lowest
      if (ofs_q >= OFS_HEADER_IV && ofs_q < OFS_HEADER_IV + IV_BYTES) begin
        hiv_d = {pop_data, hiv_q[95:32]};
      end
      if (ofs_q >= OFS_CFG_IV && ofs_q < OFS_CFG_IV + IV_BYTES) begin
        civ_d = {pop_data, civ_q[95:32]};
      end
      // address then value; an all-ones address marks an unused pair
      if (ofs_q >= OFS_REG_INIT && ofs_q < OFS_REG_INIT + REG_INIT_BYTES) begin
        if (ofs_q[2] == OFS_REG_INIT[2]) begin
          pair_addr_d = pop_data;
        end else if (pair_addr_q != 32'hFFFFFFFF) begin
          wr_d = 1'b1;
          wa_d = pair_addr_q;
          wv_d = pop_data;
        end
      end
      if (ofs_q == HEADER_BYTES - 12'h4 && st_d == PARSE_RUN) begin
        st_d = PARSE_DONE;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q <= PARSE_RUN;
      ofs_q <= OFS_WIDTH_PATTERN + 12'h10;  // pattern bytes are consumed by width detect
      key_q <= KEY_NONE;
      pair_addr_q <= 32'hFFFFFFFF;
      {f_lst_q, f_ll_q, f_llt_q, f_cla_q} <= '0;
      {f_cl_q, f_clt_q, f_sh_q, f_mo_q} <= '0;
      hiv_q <= '0;
      civ_q <= '0;
      wr_q <= 1'b0;
      wa_q <= 32'h0;
      wv_q <= 32'h0;
    end else begin
      st_q <= st_d;
      ofs_q <= ofs_d;
      key_q <= key_d;
      pair_addr_q <= pair_addr_d;
      {f_lst_q, f_ll_q, f_llt_q, f_cla_q} <= {f_lst_d, f_ll_d, f_llt_d, f_cla_d};
      {f_cl_q, f_clt_q, f_sh_q, f_mo_q} <= {f_cl_d, f_clt_d, f_sh_d, f_mo_d};
      hiv_q <= hiv_d;
      civ_q <= civ_d;
      wr_q <= wr_d;
      wa_q <= wa_d;
      wv_q <= wv_d;
    end
  end

  // ==========================================================
  // key source decode
  key_src_t ksrc;
  always_comb begin
    unique case (key_q)
      KEY_NONE: ksrc = KSRC_NONE;
      KEY_FUSE_RED: ksrc = KSRC_FUSE_RED;
      KEY_FUSE_BLACK: ksrc = KSRC_FUSE_BLACK;
      KEY_BATT_RED: ksrc = KSRC_BATT_RED;
      KEY_BATT_BLACK: ksrc = KSRC_BATT_BLACK;
      KEY_HDR_BLACK: ksrc = KSRC_HDR_BLACK;
      default: ksrc = KSRC_INVALID;
    endcase
  end

  assign bus_width_o = width_q;
  assign key_source_o = ksrc;
  assign encrypted_o = (ksrc != KSRC_NONE);
  assign loader_start_o = f_lst_q;
  assign loader_len_o = f_ll_q;
  assign loader_total_len_o = f_llt_q;
  assign cfg_load_addr_o = f_cla_q;
  assign cfg_len_o = f_cl_q;
  assign cfg_total_len_o = f_clt_q;
  assign shutter_o = f_sh_q;
  assign meta_offset_o = f_mo_q;
  // vectors only matter when a key is in use
  assign header_iv_o = encrypted_o ? hiv_q : 96'h0;
  assign cfg_iv_o = encrypted_o ? civ_q : 96'h0;
  assign reg_wr_o = wr_q;
  assign reg_addr_o = wa_q;
  assign reg_data_o = wv_q;
  assign header_done_o = (st_q == PARSE_DONE);
  assign boot_error_o = (st_q == PARSE_FAIL);
endmodule

// *** design/boot_loader_pkg.sv ***
// constants for the parallel boot image loader
package boot_loader_pkg;

  // ==========================================================
  // header field byte offsets
  localparam logic [11:0] OFS_WIDTH_PATTERN = 12'h000;
  localparam logic [11:0] OFS_FLASH_MODE = 12'h010;
  localparam logic [11:0] OFS_IMAGE_ID = 12'h014;
  localparam logic [11:0] OFS_KEY_SOURCE = 12'h018;
  localparam logic [11:0] OFS_LOADER_START = 12'h01C;
  localparam logic [11:0] OFS_CFG_LOAD_ADDR = 12'h020;
  localparam logic [11:0] OFS_CFG_LEN = 12'h024;
  localparam logic [11:0] OFS_CFG_TOTAL_LEN = 12'h028;
  localparam logic [11:0] OFS_LOADER_LEN = 12'h02C;
  localparam logic [11:0] OFS_LOADER_TOTAL_LEN = 12'h030;
  localparam logic [11:0] OFS_ATTRIBUTES = 12'h034;
  localparam logic [11:0] OFS_HEADER_IV = 12'h064;
  localparam logic [11:0] OFS_SHUTTER = 12'h070;
  localparam logic [11:0] OFS_CFG_IV = 12'h074;
  localparam logic [11:0] OFS_META_OFFSET = 12'h0C4;
  localparam logic [11:0] OFS_REG_INIT = 12'h128;
  localparam logic [11:0] REG_INIT_BYTES = 12'h800;
  localparam logic [11:0] HEADER_BYTES = 12'hF80;
  localparam logic [11:0] IV_BYTES = 12'h00C;

  // ==========================================================
  // header values
  localparam logic [31:0] FLASH_MODE_WORD = 32'hAA995566;
  localparam logic [31:0] KEY_NONE = 32'h00000000;
  localparam logic [31:0] KEY_FUSE_RED = 32'hA5C3C5A3;
  localparam logic [31:0] KEY_FUSE_BLACK = 32'hA5C3C5A5;
  localparam logic [31:0] KEY_BATT_RED = 32'h3A5C3C5A;
  localparam logic [31:0] KEY_BATT_BLACK = 32'h3A5C3C59;
  localparam logic [31:0] KEY_HDR_BLACK = 32'hA35C7C53;
  // width-detect sync byte seen on the low data lane
  localparam logic [7:0] WIDTH_SYNC_X8 = 8'hDD;
  localparam logic [7:0] WIDTH_SYNC_X16 = 8'h22;
  localparam logic [7:0] WIDTH_SYNC_X32 = 8'h44;

  // ==========================================================
  // buffering and flow control
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 32;
  localparam int HOLD_MARGIN = 24;
  // port clock 48 ns against a 4 ns system clock: cycles per port clock
  localparam int PORT_CLK_NS = 48;
  localparam int SYS_CLK_NS = 4;
  localparam int PORT_CLK_CYCLES = (PORT_CLK_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

  typedef enum logic [1:0] {
    WIDTH_X8,
    WIDTH_X16,
    WIDTH_X32
  } bus_width_t;

  typedef enum logic [2:0] {
    KSRC_NONE,
    KSRC_FUSE_RED,
    KSRC_FUSE_BLACK,
    KSRC_BATT_RED,
    KSRC_BATT_BLACK,
    KSRC_HDR_BLACK,
    KSRC_INVALID
  } key_src_t;

endpackage

// *** design/loader_fifo.sv ***
// synchronous FIFO between the port capture and the header parser
`timescale 1ns/1ps
module loader_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  // fill level
  output logic [$clog2(DEPTH):0] level_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready_o = (cnt_q != AW'(0) + (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_q[rd_q];
  assign level_o = cnt_q;

  always_comb begin
    wr_d = push ? wr_q + AW'(1) : wr_q;
    rd_d = pop ? rd_q + AW'(1) : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end
endmodule

// *** tb/boot_host_model.sv ***
// host model driving the configuration port and pacing on flow hold
`timescale 1ns/1ps
module boot_host_model (
  // clock
  input wire logic clk_i,
  // port pins
  input wire logic flow_hold_i,
  output logic config_port_clock_o,
  output logic port_select_n_o,
  output logic read_write_n_o,
  output logic [31:0] port_data_lines_o,
  // pacing limit used up
  output logic stall_o
);
  initial begin
    config_port_clock_o = 1'b0;
    port_select_n_o = 1'b1;
    read_write_n_o = 1'b0;
    port_data_lines_o = 32'h0;
    stall_o = 1'b0;
  end
  // ==========================================================
  // half a 48 ns port clock is six system clocks
  task automatic half(input logic lvl);
    config_port_clock_o = lvl;
    repeat (6) @(negedge clk_i);
  endtask
  // data stays put for the whole port period, across the rising edge
  task automatic beat(input logic [31:0] d);
    int n;
    n = 0;
    while (flow_hold_i === 1'b1 && n < 2000) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 2000) stall_o = 1'b1;
    port_data_lines_o = d;
    half(1'b0);
    half(1'b1);
  endtask
  task automatic open_port(input logic rw);
    port_select_n_o = 1'b0;
    read_write_n_o = rw;
    repeat (2) @(negedge clk_i);
  endtask
  // released lines show the inverse of the last value, never a stale copy
  task automatic close_port();
    half(1'b0);
    port_select_n_o = 1'b1;
    port_data_lines_o = ~port_data_lines_o;
    repeat (2) @(negedge clk_i);
  endtask
endmodule

// *** tb/boot_loader_sva.sv ***
// concurrent checks on the boot image loader ports
`timescale 1ns/1ps
module boot_loader_sva (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // port pins
  input wire logic port_select_n_i,
  input wire logic read_write_n_i,
  input wire logic [31:0] readback_data_i,
  input wire logic [31:0] port_data_lines_o,
  input wire logic [31:0] port_data_lines_oe_o,
  input wire logic flow_hold_o,
  // decoded header and status
  input wire logic [1:0] bus_width_o,
  input wire logic [2:0] key_source_o,
  input wire logic encrypted_o,
  input wire logic [31:0] loader_start_o,
  input wire logic [31:0] cfg_total_len_o,
  input wire logic [31:0] meta_offset_o,
  input wire logic [95:0] header_iv_o,
  input wire logic [95:0] cfg_iv_o,
  input wire logic reg_wr_o,
  input wire logic [31:0] reg_addr_o,
  input wire logic header_done_o,
  input wire logic boot_error_o
);
  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // select and direction pass a synchroniser first, hence the settling span
  chk_read_drive: assert property ((!port_select_n_i && read_write_n_i) [*4]
    |=> port_data_lines_oe_o == 32'hFFFFFFFF) else $error("data lines not driven on read");
  chk_read_quiet: assert property ((port_select_n_i || !read_write_n_i) [*4]
    |=> port_data_lines_oe_o == 32'h0) else $error("data lines driven outside read");
  chk_read_data: assert property ((port_data_lines_oe_o == 32'hFFFFFFFF && $past(
    port_data_lines_oe_o) == 32'hFFFFFFFF) |-> port_data_lines_o == $past(readback_data_i))
    else $error("read data does not follow readback word");
  chk_hold_idle: assert property (port_select_n_i [*4] |=> !flow_hold_o)
    else $error("flow hold raised while deselected");
  chk_enc_flag: assert property ($stable(key_source_o) [*2]
    |-> encrypted_o == (key_source_o != 3'h0)) else $error("encrypted flag disagrees with key");
  chk_iv_plain: assert property ((!encrypted_o) [*2]
    |-> header_iv_o == 96'h0 && cfg_iv_o == 96'h0) else $error("iv nonzero while plain");
  chk_wr_single: assert property (reg_wr_o |=> !reg_wr_o)
    else $error("register write strobe longer than one cycle");
  chk_wr_skip: assert property (reg_wr_o |-> reg_addr_o != 32'hFFFFFFFF)
    else $error("skipped register pair was written");
  chk_err_sticky: assert property (boot_error_o |=> boot_error_o)
    else $error("boot error cleared without reset");
  chk_err_stop: assert property (boot_error_o |-> !header_done_o && !reg_wr_o)
    else $error("processing continued after boot error");
  chk_fields_hold: assert property (header_done_o |=> $stable(loader_start_o) &&
    $stable(meta_offset_o) && $stable(bus_width_o) && $stable(cfg_total_len_o))
    else $error("header field changed after completion");
endmodule

bind boot_image_loader boot_loader_sva boot_loader_sva_inst (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .port_select_n_i(port_select_n_i),
  .read_write_n_i(read_write_n_i), .readback_data_i(readback_data_i),
  .port_data_lines_o(port_data_lines_o), .port_data_lines_oe_o(port_data_lines_oe_o),
  .flow_hold_o(flow_hold_o), .bus_width_o(bus_width_o), .key_source_o(key_source_o),
  .encrypted_o(encrypted_o), .loader_start_o(loader_start_o), .cfg_total_len_o(cfg_total_len_o),
  .meta_offset_o(meta_offset_o), .header_iv_o(header_iv_o), .cfg_iv_o(cfg_iv_o),
  .reg_wr_o(reg_wr_o), .reg_addr_o(reg_addr_o), .header_done_o(header_done_o),
  .boot_error_o(boot_error_o)
);

// *** tb/testbench.sv ***
// self-checking bench for the boot image loader
`timescale 1ns/1ps
module testbench;
  import boot_loader_pkg::*;
  localparam logic [31:0] ID = 32'h5A3C9611;  // arbitrary value
  logic clk_i, sys_rst_i, pclk, sel_n, rw_n, hold, stall, enc, rwr, done, err;
  logic [31:0] pdin, pdo, pdoe, rbk, ls, ll, lt, ca, cl, ct, sh, mo, ra, rd;
  logic [1:0] bw;
  logic [2:0] ks;
  logic [95:0] hiv, civ;
  logic [7:0] img [0:4095];
  logic [63:0] wrq [$];
  logic [31:0] keys [7] = '{KEY_NONE, KEY_FUSE_RED, KEY_FUSE_BLACK, KEY_BATT_RED,
    KEY_BATT_BLACK, KEY_HDR_BLACK, 32'h0F0F1234};
  int n_errors = 0;
  int tests_run = 0;
  int n;

  boot_host_model host (.clk_i(clk_i), .flow_hold_i(hold), .config_port_clock_o(pclk),
    .port_select_n_o(sel_n), .read_write_n_o(rw_n), .port_data_lines_o(pdin), .stall_o(stall));
  boot_image_loader #(.IMAGE_ID_VALUE(ID)) boot_image_loader_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .config_port_clock_i(pclk), .port_select_n_i(sel_n),
    .read_write_n_i(rw_n), .port_data_lines_i(pdin), .port_data_lines_o(pdo),
    .port_data_lines_oe_o(pdoe), .flow_hold_o(hold), .readback_data_i(rbk), .bus_width_o(bw),
    .key_source_o(ks), .encrypted_o(enc), .loader_start_o(ls), .loader_len_o(ll),
    .loader_total_len_o(lt), .cfg_load_addr_o(ca), .cfg_len_o(cl), .cfg_total_len_o(ct),
    .shutter_o(sh), .meta_offset_o(mo), .header_iv_o(hiv), .cfg_iv_o(civ), .reg_wr_o(rwr),
    .reg_addr_o(ra), .reg_data_o(rd), .header_done_o(done), .boot_error_o(err));

  // ==========================================================
  // helpers
  task automatic stop_test();
    if (n_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [95:0] e, input logic [95:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] w(input int a);
    return {img[a + 3], img[a + 2], img[a + 1], img[a]};
  endfunction
  function automatic logic [95:0] iv(input int a);
    return {w(a + 8), w(a + 4), w(a)};
  endfunction
  function automatic void put(input int a, input logic [31:0] v);
    {img[a + 3], img[a + 2], img[a + 1], img[a]} = v;
  endfunction
  task automatic do_reset();
    sys_rst_i = 1'b1;
    repeat (3) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (3) @(negedge clk_i);
  endtask
  // random image; pairs with the all-ones address are expected to be skipped
  task automatic build(input logic [31:0] key, input logic [31:0] id);
    for (int i = 0; i < 4096; i++) img[i] = 8'($urandom);
    put(OFS_FLASH_MODE, FLASH_MODE_WORD);
    put(OFS_IMAGE_ID, id);
    put(OFS_KEY_SOURCE, key);
    put(OFS_REG_INIT + 8, 32'hFFFFFFFF);
    put(OFS_REG_INIT + 2040, 32'hFFFFFFFF);
    wrq.delete();
    for (int a = OFS_REG_INIT; a < OFS_REG_INIT + REG_INIT_BYTES; a += 8)
      if (w(a) != 32'hFFFFFFFF) wrq.push_back({w(a), w(a + 4)});
  endtask
  // unused upper lanes carry noise that must be ignored
  task automatic send(input int wb, input int last);
    logic [31:0] j;
    host.open_port(1'b0);
    host.beat(wb == 1 ? {24'h0, WIDTH_SYNC_X8} : {24'h0, WIDTH_SYNC_X16});
    for (int a = 16; a < last; a += wb) begin
      j = $urandom;
      host.beat(wb == 1 ? {j[31:8], img[a]} : {j[31:16], img[a + 1], img[a]});
    end
    host.close_port();
  endtask
  task automatic wait_flag(input bit want_err);
    for (n = 0; n < 300 && (want_err ? err : done) !== 1'b1; n++) @(negedge clk_i);
    if (n >= 300) begin
      n_errors++;
      stop_test();
    end
  endtask

  // ==========================================================
  // monitors
  always @(negedge clk_i) begin
    if (rwr === 1'b1) chk("reg_pair", wrq.size() ? wrq.pop_front() : 64'h0, {ra, rd});
  end
  always @(posedge stall) begin
    n_errors++;
    stop_test();
  end
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // ==========================================================
  // scenarios
  initial begin
    sys_rst_i = 1'b1;
    rbk = 32'h0;
    n = $urandom(32'h5B72);
    do_reset();
    // traffic for another device: shared clock and data, this select held high
    host.beat({24'h0, WIDTH_SYNC_X16});
    repeat (6) @(negedge clk_i);
    chk("width_deselected", WIDTH_X8, bw);
    for (int k = 0; k < 7; k++) begin
      do_reset();
      build(keys[k], ID);
      send(2, 32'h1C);
      repeat (4) @(negedge clk_i);
      chk("width_x16", WIDTH_X16, bw);
      chk("key_source", k, ks);
      chk("encrypted", k != 0, enc);
    end
    // first a broken flash mode word, then a foreign identifier
    for (int b = 0; b < 2; b++) begin
      do_reset();
      build(KEY_NONE, b ? ~ID : ID);
      if (b == 0) put(OFS_FLASH_MODE, ~FLASH_MODE_WORD);
      send(2, 32'h20);
      wait_flag(1'b1);
      chk("bad_hdr_done", 1'b0, done);
    end
    do_reset();
    host.open_port(1'b0);
    host.beat({24'h0, WIDTH_SYNC_X32});
    repeat (4) @(negedge clk_i);
    chk("width_x32", WIDTH_X32, bw);
    chk("hold_x32", 1'b1, hold);
    host.close_port();
    do_reset();
    build(KEY_HDR_BLACK, ID);
    send(1, HEADER_BYTES);
    wait_flag(1'b0);
    chk("error", 1'b0, err);
    chk("width_x8", WIDTH_X8, bw);
    chk("key_hdr", KSRC_HDR_BLACK, ks);
    chk("loader_start", w(OFS_LOADER_START), ls);
    chk("loader_len", w(OFS_LOADER_LEN), ll);
    chk("loader_total", w(OFS_LOADER_TOTAL_LEN), lt);
    chk("cfg_addr", w(OFS_CFG_LOAD_ADDR), ca);
    chk("cfg_len", w(OFS_CFG_LEN), cl);
    chk("cfg_total", w(OFS_CFG_TOTAL_LEN), ct);
    chk("header_iv", iv(OFS_HEADER_IV), hiv);
    chk("cfg_iv", iv(OFS_CFG_IV), civ);
    chk("shutter", w(OFS_SHUTTER), sh);
    chk("meta_offset", w(OFS_META_OFFSET), mo);
    chk("reg_left", 0, wrq.size());
    host.open_port(1'b1);
    for (int i = 0; i < 3; i++) begin
      rbk = $urandom;
      repeat (6) @(negedge clk_i);
      chk("read_data", rbk, pdo);
      chk("read_enable", 32'hFFFFFFFF, pdoe);
    end
    host.close_port();
    stop_test();
  end
endmodule
